// ---- design/scp_prescaler.sv ----
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module scp_prescaler
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire scp_pkg::scp_addr_s        s_axi_aw,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire scp_pkg::scp_wdata_s       s_axi_w,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic [1:0]                     s_axi_bresp,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire scp_pkg::scp_addr_s        s_axi_ar,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output scp_pkg::scp_rdata_s            s_axi_r,
    input  wire logic                      clock_out_fuse,
    input  wire logic                      divide_by_eight_fuse,
    input  wire logic [7:0]                factory_trim,
    output logic                           io_clock_en,
    output logic                           core_clock_en,
    output logic                           flash_clock_en,
    output logic                           clock_out_pin_o,
    output logic                           clock_out_pin_oe,
    output logic [7:0]                     rc_osc_trim,
    output logic                           trim_range_bit,
    output logic [6:0]                     trim_fine
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                   aw_have_q;
    logic                   w_have_q;
    logic [11:0]            aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    scp_pkg::scp_rdata_s    r_q;

    logic                   pce_q;
    logic [1:0]             pce_cnt_q;
    logic [3:0]             sel_q;
    logic                   pend_q;
    logic [7:0]             pend_lim_q;
    logic [7:0]             lim_q;
    logic [7:0]             count_q;
    logic                   tick_q;
    logic [7:0]             trim_q;

    logic                   wr_go;
    logic                   wr_ctrl;
    logic                   wr_trim;
    logic                   wr_hit;
    logic [7:0]             wr_byte;
    logic                   wr_unlock;
    logic                   wr_select;
    logic                   rd_go;
    logic                   rd_ctrl;
    logic                   rd_trim;
    logic [7:0]             ctrl_view;
    logic [7:0]             sel_lim;
    logic [3:0]             reset_sel;
    logic                   tick_now;
    logic [7:0]             count_d;

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    // Each channel is taken on its own handshake
    // Ready drops while a beat is held
    // Both beats held: write executes once
    // Execution waits for the previous response
    // No queue: one write held, one awaiting response at most
    // Held beats cleared when the write executes
    // A fresh beat may arrive from the next cycle
    // Earliest answer: two edges after handshake
    // Address and data may arrive in either order
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign wr_go         = aw_have_q && w_have_q && !bvalid_q;

    // Hold write address and data until both are present
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_aw.addr;
            end
            else if (wr_go)
                aw_have_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_w.data;
                w_strb_q <= s_axi_w.strb;
            end
            else if (wr_go)
                w_have_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Registers are one byte wide
    // Upper lanes are accepted and dropped
    // Lane 0 strobe low: write has no effect
    // Unmapped address: nothing changes
    // Unmapped address still gets a response
    // Unlock needs the exact unlock byte
    // Bits six to four also must be zero
    // Select write needs the enable bit clear
    // Select write needs the window open
    // Decode is purely combinational
    // Only byte lane 0 carries register data
    assign wr_byte   = w_data_q[7:0];
    assign wr_hit    = (aw_addr_q == scp_pkg::ADDR_CONTROL) ||
                       (aw_addr_q == scp_pkg::ADDR_TRIM);
    assign wr_ctrl   = wr_go && w_strb_q[0] && (aw_addr_q == scp_pkg::ADDR_CONTROL);
    assign wr_trim   = wr_go && w_strb_q[0] && (aw_addr_q == scp_pkg::ADDR_TRIM);
    // Unlock only on exact 0x80, others zero
    assign wr_unlock = wr_ctrl && (wr_byte == scp_pkg::UNLOCK_VAL);
    // Select write needs open window and cleared enable bit
    assign wr_select = wr_ctrl && pce_q && !wr_byte[scp_pkg::PCE_BIT];

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= scp_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? scp_pkg::RESP_OKAY : scp_pkg::RESP_DECERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // Change-enable window
    // ------------------------------------------------------------
    // Window guards select against stray writes
    // Opens on the unlock write edge
    // Counter starts at zero on that edge
    // Enable reads set for four edges
    // Closes at the fifth edge at the latest
    // A select write closes it at once
    // Select on the closing edge still lands
    // Unlock inside the window changes nothing
    // No restart, so the window cannot be held
    // Window state is visible in bit seven
    // Reset closes the window
    // Counter width covers exactly four edges
    // Set by unlock, closed after four cycles or by a select write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pce_q     <= 1'b0;
            pce_cnt_q <= 2'h0;
        end
        else if (pce_q)
        begin
            // A second unlock is ignored here
            pce_cnt_q <= pce_cnt_q + 2'h1;
            if (wr_select || pce_cnt_q == scp_pkg::PCE_LAST)
                pce_q <= 1'b0;
        end
        else if (wr_unlock)
        begin
            pce_q     <= 1'b1;
            pce_cnt_q <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Select register and pending factor
    // ------------------------------------------------------------
    // Select stored as written, reserved codes too
    // Stored code reads back unchanged
    // Terminal count is factor minus one
    // Factor one: terminal count zero
    // Factor 256: terminal count all ones
    // Count queued, not applied at once
    // Queued count waits for an old boundary
    // Applying mid-period would shorten a period
    // A short period would be a glitch
    // Second select before boundary overwrites queue
    // Reset value comes from the fuse
    // Fuse is only looked at during reset
    // Code to terminal count; reserved codes fall back to 256
    assign sel_lim = (wr_byte[3:0] > scp_pkg::SEL_MAX) ? scp_pkg::LIM_MAX :
                     8'((9'h001 << wr_byte[3:0]) - 9'h001);

    // Reset value from the divide-by-eight fuse
    assign reset_sel = divide_by_eight_fuse ? scp_pkg::SEL_DIV8
                                            : scp_pkg::SEL_DIV1;

    // Store select and queue its terminal count for the next boundary
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_q      <= reset_sel;
            pend_q     <= 1'b0;
            pend_lim_q <= 8'h00;
        end
        else if (wr_select)
        begin
            sel_q      <= wr_byte[3:0];
            pend_q     <= 1'b1;
            pend_lim_q <= sel_lim;
        end
        else if (tick_now)
            pend_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Prescale counter
    // ------------------------------------------------------------
    // Counter wraps at the terminal count
    // Wrap point gives one tick per period
    // Tick registered, so enables are glitch free
    // Limit swapped only as the counter wraps
    // Old period always finishes in full
    // New period then starts from zero
    // Never a period shorter than old or new
    // Change takes effect within old plus new
    // Counter held at zero during reset
    // Reset limit matches the reset select
    // Count value never reaches the bus
    // No software can predict the swap edge
    // Counter runs every undivided cycle and is never readable
    assign tick_now = (count_q == lim_q);
    assign count_d  = tick_now ? 8'h00 : count_q + 8'h01;

    // New factor only at an old-period boundary
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_q <= 8'h00;
            lim_q   <= divide_by_eight_fuse ? 8'h07 : 8'h00;
            tick_q  <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            tick_q  <= tick_now;
            if (tick_now && pend_q)
                lim_q <= pend_lim_q;
        end
    end

    // ------------------------------------------------------------
    // Divided clock enables and clock pin
    // ------------------------------------------------------------
    // Divided domains are clock enables here
    // Each enable is high one cycle per period
    // Factor one: enables stay high
    // All three share one register, never skew
    // Pin shows the tick stream, not a square wave
    // Pin driven whenever the fuse is set
    // Pin overrides the normal port function
    // Reset: pin follows the undivided clock
    // Fuse clear: pin driver off, value low
    // Pin logic uses no second clock
    // One tick feeds every divided domain
    assign io_clock_en      = tick_q;
    assign core_clock_en    = tick_q;
    assign flash_clock_en   = tick_q;
    // Pin overrides its port function while the fuse is set
    assign clock_out_pin_oe = clock_out_fuse;
    // Divided tick in run, undivided while reset holds
    assign clock_out_pin_o  = clock_out_fuse && (!aresetn || tick_q);

    // ------------------------------------------------------------
    // Oscillator trim
    // ------------------------------------------------------------
    // Trim drives the oscillator directly
    // Top bit selects the range
    // Lower bits tune inside the range
    // Written value takes effect next cycle
    // Factory value at reset, software may overwrite
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            trim_q <= factory_trim;
        else if (wr_trim)
            trim_q <= wr_byte;
    end

    assign rc_osc_trim    = trim_q;
    assign trim_range_bit = trim_q[scp_pkg::RANGE_BIT];
    assign trim_fine      = trim_q[scp_pkg::FINE_W-1:0];

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // One read in flight at most
    // Address ready drops while data waits
    // Data held until the read is accepted
    // Unmapped read returns zero with error
    // Bits six to four read as zero
    assign ctrl_view     = {pce_q, 3'h0, sel_q};
    assign s_axi_arready = !rvalid_q;
    assign rd_go         = s_axi_arvalid && s_axi_arready;
    assign rd_ctrl       = (s_axi_ar.addr == scp_pkg::ADDR_CONTROL);
    assign rd_trim       = (s_axi_ar.addr == scp_pkg::ADDR_TRIM);

    // Registered read data and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            r_q      <= '0;
        end
        else if (rd_go)
        begin
            rvalid_q  <= 1'b1;
            r_q.data  <= rd_ctrl ? {24'h000000, ctrl_view} :
                         rd_trim ? {24'h000000, trim_q} : 32'h00000000;
            r_q.resp  <= (rd_ctrl || rd_trim) ? scp_pkg::RESP_OKAY
                                              : scp_pkg::RESP_DECERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_r      = r_q;

endmodule

// ---- design/scp_pkg.sv ----
package scp_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          REG_W       = 8;

    // Register indices and their byte addresses (index times four)
    localparam logic [7:0]  IDX_CONTROL = 8'h61;
    localparam logic [7:0]  IDX_TRIM    = 8'h66;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'h184;
    localparam logic [ADDR_W-1:0] ADDR_TRIM    = 12'h198;

    // ------------------------------------------------------------
    // Control register layout and values
    // ------------------------------------------------------------
    localparam int          PCE_BIT     = 7;
    localparam int          SEL_LSB     = 0;
    localparam int          SEL_W       = 4;
    localparam logic [7:0]  UNLOCK_VAL  = 8'h80;
    localparam logic [3:0]  SEL_DIV1    = 4'h0;
    localparam logic [3:0]  SEL_DIV8    = 4'h3;
    localparam logic [3:0]  SEL_MAX     = 4'h8;
    localparam logic [7:0]  LIM_MAX     = 8'hFF;

    // Trim register layout
    localparam int          RANGE_BIT   = 7;
    localparam int          FINE_W      = 7;

    // Change-enable window, in clock cycles
    localparam logic [1:0]  PCE_LAST    = 2'h3;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // Channel payloads
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0]        prot;
    } scp_addr_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [3:0]        strb;
    } scp_wdata_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0]        resp;
    } scp_rdata_s;

endpackage

// ---- tb/scp_prescaler_props.sv ----
`timescale 1ns/100ps
module scp_prescaler_props
(
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire scp_pkg::scp_rdata_s s_axi_r,
    input wire logic                clock_out_fuse,
    input wire logic                io_clock_en,
    input wire logic                core_clock_en,
    input wire logic                flash_clock_en,
    input wire logic                clock_out_pin_o,
    input wire logic                clock_out_pin_oe,
    input wire logic [7:0]          rc_osc_trim,
    input wire logic                trim_range_bit,
    input wire logic [6:0]          trim_fine
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Pin driver follows the fuse
    property p_oe; clock_out_pin_oe == clock_out_fuse; endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from fuse");
    // Pin carries the divided tick
    property p_pin; clock_out_fuse |-> clock_out_pin_o == io_clock_en; endproperty
    a_pin: assert property (p_pin) else $error("pin not divided clock");
    // All three clock enables share one factor
    property p_en; io_clock_en == core_clock_en && core_clock_en == flash_clock_en; endproperty
    a_en: assert property (p_en) else $error("clock enables disagree");
    // Trim split outputs
    property p_trim;
        trim_range_bit == rc_osc_trim[7] && trim_fine == rc_osc_trim[6:0];
    endproperty
    a_trim: assert property (p_trim) else $error("trim fields wrong");
    // Write answered two edges after both handshakes: capture, then execute
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    // Read answered one cycle after address
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read response late");
    // Read data held while stalled
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_r); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    // Unused upper data bits read zero
    property p_upper; s_axi_rvalid |-> s_axi_r.data[31:8] == 24'h000000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");

    // Main scenarios reached
    c_tick: cover property (io_clock_en ##1 !io_clock_en);
    c_decerr: cover property (s_axi_bvalid && s_axi_bresp == scp_pkg::RESP_DECERR);
    c_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 0, clock_out_fuse = 1, divide_by_eight_fuse = 1;
    logic [7:0] factory_trim = 8'h00;
    scp_pkg::scp_addr_s  s_axi_aw = '0, s_axi_ar = '0;
    scp_pkg::scp_wdata_s s_axi_w  = '0;
    scp_pkg::scp_rdata_s s_axi_r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic io_clock_en, core_clock_en, flash_clock_en, clock_out_pin_o, clock_out_pin_oe;
    logic trim_range_bit;
    logic [1:0] s_axi_bresp;
    logic [7:0] rc_osc_trim, v;
    logic [6:0] trim_fine;
    logic [31:0] d;
    logic [1:0] rs;
    int error_cnt = 0, n_tests = 0, p;
    localparam logic [11:0] CT = scp_pkg::ADDR_CONTROL;

    scp_prescaler i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_aw,
        .s_axi_wvalid, .s_axi_wready, .s_axi_w, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_ar, .s_axi_rvalid, .s_axi_rready, .s_axi_r,
        .clock_out_fuse, .divide_by_eight_fuse, .factory_trim, .io_clock_en, .core_clock_en,
        .flash_clock_en, .clock_out_pin_o, .clock_out_pin_oe, .rc_osc_trim, .trim_range_bit,
        .trim_fine);

    // Clock and overall limit
    always #20 aclk = ~aclk;
    initial
    begin
        #4000000;
        tmo();
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tmo;
        error_cnt++;
        $display("mismatch at %0t: wait expired", $time);
        conclude();
    endtask
    function automatic int fac(input logic [3:0] s);
        return (s > 4'h8) ? 256 : (1 << s);
    endfunction

    // ------------------------------------------------------------
    // Bus and clock tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] x, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_aw      <= '{a, 3'h0};
        s_axi_w       <= '{{24'h000000, x}, 4'h1};
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        if (n >= 40) tmo();
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_ar      <= '{a, 3'h0};
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        if (n >= 40) tmo();
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        d  = s_axi_r.data;
        rs = s_axi_r.resp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
        chk(rs, scp_pkg::RESP_OKAY);
    endtask
    task automatic setsel(input logic [7:0] x);
        // No interrupt source in the bench, so the pair is never split
        wr(CT, scp_pkg::UNLOCK_VAL, scp_pkg::RESP_OKAY);
        wr(CT, x, scp_pkg::RESP_OKAY);
    endtask
    task automatic period;
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge aclk);
                n++;
            end while (io_clock_en !== 1'b1 && n < 600);
            if (n >= 600) tmo();
            chk(core_clock_en, 1);
            chk(flash_clock_en, 1);
        end
        p = n;
    endtask
    task automatic do_reset(input logic d8);
        aresetn              <= 1'b0;
        divide_by_eight_fuse <= d8;
        factory_trim         <= 8'($urandom);
        repeat (6) @(posedge aclk);
        chk(clock_out_pin_o, 1);
        aresetn <= 1'b1;
        rchk(CT, d8 ? scp_pkg::SEL_DIV8 : scp_pkg::SEL_DIV1);
        rchk(scp_pkg::ADDR_TRIM, factory_trim);
        period();
        chk(p, d8 ? 8 : 1);
        $display("reset test done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(59458));
        do_reset(1'b1);
        for (int i = 0; i < 16; i++)
        begin
            setsel(8'(i));
            rchk(CT, 32'(i));
            period();
            chk(p, fac(4'(i)));
        end
        $display("select test done");
        setsel(8'h73);
        rchk(CT, 8'h03);
        wr(CT, 8'h81, scp_pkg::RESP_OKAY);
        wr(CT, 8'h05, scp_pkg::RESP_OKAY);
        rchk(CT, 8'h03);
        wr(CT, 8'h80, scp_pkg::RESP_OKAY);
        rchk(CT, 8'h83);
        wr(CT, 8'h06, scp_pkg::RESP_OKAY);
        rchk(CT, 8'h03);
        wr(CT, 8'h80, scp_pkg::RESP_OKAY);
        setsel(8'h02);
        rchk(CT, 8'h03);
        $display("unlock test done");
        repeat (8)
        begin
            v = 8'($urandom);
            wr(scp_pkg::ADDR_TRIM, v, scp_pkg::RESP_OKAY);
            rchk(scp_pkg::ADDR_TRIM, v);
            chk(rc_osc_trim, v);
            chk(trim_range_bit, v[7]);
            chk(trim_fine, v[6:0]);
        end
        wr(12'h1FC, 8'h55, scp_pkg::RESP_DECERR);
        rd(12'h1FC);
        chk(d, 0);
        chk(rs, scp_pkg::RESP_DECERR);
        $display("trim and decode test done");
        do_reset(1'b0);
        clock_out_fuse <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(clock_out_pin_oe, 0);
        chk(clock_out_pin_o, 0);
        $display("fuse test done");
        conclude();
    end
endmodule

bind scp_prescaler scp_prescaler_props i_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_r, .clock_out_fuse,
    .io_clock_en, .core_clock_en, .flash_clock_en, .clock_out_pin_o, .clock_out_pin_oe,
    .rc_osc_trim, .trim_range_bit, .trim_fine);
